/* File: hw/ibm_loop.sv */
module ibm_loop
  import ibm_pkg::*;
(
  // Clock and control
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  input  wire logic                  step,
  // Sensed input
  input  wire logic signed [X_W-1:0] x,
  // Comparator decision
  output logic                       decision
);

  logic signed [INT_W-1:0] i1;
  logic signed [INT_W-1:0] i2;
  logic                    fb;
  logic signed [INT_W-1:0] next_i1;
  logic signed [INT_W-1:0] next_i2;
  logic                    next_fb;
  logic signed [INT_W-1:0] xe;
  logic signed [INT_W-1:0] dac;
  logic signed [SUM_W+1:0] v4;

  function automatic logic signed [INT_W-1:0] sat(input logic signed [SUM_W-1:0] v);
    logic signed [SUM_W-1:0] hi;
    logic signed [SUM_W-1:0] lo;
    hi = SUM_W'(INT_MAX);
    lo = SUM_W'(INT_MIN);
    if (v > hi)
    begin
      sat = INT_MAX;
    end
    else if (v < lo)
    begin
      sat = INT_MIN;
    end
    else
    begin
      sat = v[INT_W-1:0];
    end
  endfunction : sat

  always_comb
  begin
    xe  = INT_W'(x);
    dac = fb ? DAC_LEVEL : -DAC_LEVEL;
    // feed-forward sum, two integrators
    // Weights 3, 1 and -2 x DAC undo the one-step DAC delay
    v4  = (SUM_W+2)'(xe) + ((SUM_W+2)'(i1) <<< 1) + (SUM_W+2)'(i1)
          + (SUM_W+2)'(i2) - ((SUM_W+2)'(dac) <<< 1);
    decision = ~v4[SUM_W+1];
    next_i1  = i1;
    next_i2  = i2;
    next_fb  = fb;
    if (step)
    begin
      next_i1 = sat(SUM_W'(i1) + SUM_W'(xe) - SUM_W'(dac));
      next_i2 = sat(SUM_W'(i2) + SUM_W'(i1));
      next_fb = decision;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      i1 <= '0;
      i2 <= '0;
      fb <= 1'b0;
    end
    else if (ce)
    begin
      i1 <= next_i1;
      i2 <= next_i2;
      fb <= next_fb;
    end
  end

  property p_dac_follows;
    @(posedge clk) disable iff (!rst_n)
    (step && ce) |=> (fb == $past(decision));
  endproperty
  a_dac_follows: assert property (p_dac_follows)
    else $error("DAC level did not follow decision");

endmodule : ibm_loop

/* File: hw/ibm_modulator.sv */
module ibm_modulator
  import ibm_pkg::*;
(
  // System
  input  wire logic                  I_CLK_SYS,
  input  wire logic                  I_NRST,
  input  wire logic                  I_CE,
  // Pins from the far side and supplies
  input  wire logic                  I_SAMPLE_CLOCK_IN,
  input  wire logic                  I_HIGH_SIDE_SUPPLY,
  input  wire logic                  I_CONTROLLER_SIDE_SUPPLY,
  input  wire logic                  I_CM_OVERVOLTAGE,
  input  wire logic                  I_ENCODED,
  // Digitised front-end sample, same clock
  input  wire logic signed [X_W-1:0] I_AIN_SAMPLE,
  // Outputs
  output logic                       O_DOUT,
  output logic                       O_CARRIER_ON,
  output logic                       O_CHOPPER,
  output logic                       O_VALID
);

  logic [1:0]  rst_q;
  logic        rst_n;
  ibm_pins_s   pins_m;
  ibm_pins_s   pins_s;
  ibm_pins_s   pins_raw;
  logic        sclk_d;
  logic        rise;

  ibm_state_e  state;
  ibm_state_e  next_state;
  logic [4:0]  period_cnt;
  logic [4:0]  next_period_cnt;
  logic [3:0]  chop_cnt;
  logic [3:0]  next_chop_cnt;
  logic        next_chop;
  logic [6:0]  mark_cnt;
  logic [6:0]  next_mark_cnt;
  logic        bit_q;
  logic        next_bit;
  logic        next_carrier;
  logic        next_dout;
  logic        next_valid;
  logic        clip_hi;
  logic        clip_lo;
  logic        step;
  logic        loop_bit;

  // Reset release through two flops
  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      rst_q <= 2'h0;
    end
    else
    begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  assign pins_raw = '{sclk:    I_SAMPLE_CLOCK_IN,
                      hs_ok:   I_HIGH_SIDE_SUPPLY,
                      cs_ok:   I_CONTROLLER_SIDE_SUPPLY,
                      cm_ov:   I_CM_OVERVOLTAGE,
                      encoded: I_ENCODED};

  // Pin synchroniser and edge history
  always_ff @(posedge I_CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins_m <= '0;
      pins_s <= '0;
      sclk_d <= 1'b0;
    end
    else if (I_CE)
    begin
      pins_m <= pins_raw;
      pins_s <= pins_m;
      sclk_d <= pins_s.sclk;
    end
  end

  assign rise    = pins_s.sclk & ~sclk_d;
  assign clip_hi = (I_AIN_SAMPLE >= CLIP_POS);
  assign clip_lo = (I_AIN_SAMPLE <= CLIP_NEG);
  assign step    = rise && (state == ST_RUN) && pins_s.hs_ok;

  ibm_loop u_loop (
    .clk      (I_CLK_SYS),
    .rst_n    (rst_n),
    .ce       (I_CE),
    .step     (step),
    .x        (I_AIN_SAMPLE),
    .decision (loop_bit)
  );

  // Startup sequencing
  always_comb
  begin
    next_state      = state;
    next_period_cnt = period_cnt;
    case (state)
      ST_OFF:
      begin
        next_period_cnt = 5'h00;
        if (pins_s.cs_ok)
        begin
          next_state = ST_START;
        end
      end
      ST_START:
      begin
        if (rise)
        begin
          next_period_cnt = period_cnt + 5'h01;
          if (period_cnt == STARTUP_LAST)
          begin
            next_state = ST_RUN;
          end
        end
      end
      ST_RUN:
      begin
        next_period_cnt = 5'h00;
      end
      default:
      begin
        next_state = ST_OFF;
      end
    endcase
    if (!pins_s.cs_ok)
    begin
      next_state = ST_OFF;
    end
    next_valid = (next_state == ST_RUN);
  end

  // Chopper and stream bit
  always_comb
  begin
    next_chop_cnt = chop_cnt;
    next_chop     = O_CHOPPER;
    next_mark_cnt = mark_cnt;
    next_bit      = bit_q;
    if (rise && (state != ST_OFF))
    begin
      next_chop_cnt = chop_cnt + 4'h1;
      if (chop_cnt == CHOP_LAST)
      begin
        next_chop = ~O_CHOPPER;
      end
    end
    if (rise)
    begin
      next_mark_cnt = (clip_hi || clip_lo) ? mark_cnt + 7'h01 : 7'h00;
      if (state != ST_RUN)
      begin
        next_bit = 1'b0;
      end
      else if (!pins_s.hs_ok)
      begin
        next_bit = 1'b0;
      end
      else if (pins_s.cm_ov)
      begin
        next_bit = 1'b1;
      end
      else if (clip_hi || clip_lo)
      begin
        next_bit = (mark_cnt == MARK_LAST) ? clip_lo : clip_hi;
      end
      else
      begin
        next_bit = loop_bit;
      end
    end
    next_carrier = bit_q;
    if (pins_s.encoded)
    begin
      next_dout = O_CARRIER_ON ^ pins_s.sclk;
    end
    else
    begin
      next_dout = O_CARRIER_ON;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state        <= ST_OFF;
      period_cnt   <= 5'h00;
      chop_cnt     <= 4'h0;
      O_CHOPPER    <= 1'b0;
      mark_cnt     <= 7'h00;
      bit_q        <= 1'b0;
      O_CARRIER_ON <= 1'b0;
      O_DOUT       <= 1'b0;
      O_VALID      <= 1'b0;
    end
    else if (I_CE)
    begin
      state        <= next_state;
      period_cnt   <= next_period_cnt;
      chop_cnt     <= next_chop_cnt;
      O_CHOPPER    <= next_chop;
      mark_cnt     <= next_mark_cnt;
      bit_q        <= next_bit;
      O_CARRIER_ON <= next_carrier;
      O_DOUT       <= next_dout;
      O_VALID      <= next_valid;
    end
  end

  property p_startup;
    @(posedge I_CLK_SYS) disable iff (!rst_n || !I_CE)
    $rose(O_VALID) |-> ($past(period_cnt) == STARTUP_LAST) && $past(rise);
  endproperty
  a_startup: assert property (p_startup)
    else $error("Valid rose before 32 sample periods");

  property p_chop;
    @(posedge I_CLK_SYS) disable iff (!rst_n || !I_CE)
    $changed(O_CHOPPER) |-> $past(rise) && ($past(chop_cnt) == CHOP_LAST);
  endproperty
  a_chop: assert property (p_chop)
    else $error("Chopper toggled off the divide by 32");

  property p_carrier;
    @(posedge I_CLK_SYS) disable iff (!rst_n || !I_CE)
    $rose(bit_q) |=> O_CARRIER_ON ##1 (O_DOUT == ($past(O_CARRIER_ON)
      ^ ($past(pins_s.encoded) & $past(pins_s.sclk))));
  endproperty
  a_carrier: assert property (p_carrier)
    else $error("Carrier did not follow a one");

  property p_uncoded;
    @(posedge I_CLK_SYS) disable iff (!rst_n || !I_CE)
    ($changed(O_DOUT) && !$past(pins_s.encoded)) |-> $past(rise, 3);
  endproperty
  a_uncoded: assert property (p_uncoded)
    else $error("Uncoded output changed off a rising edge");

  property p_encoded;
    @(posedge I_CLK_SYS) disable iff (!rst_n || !I_CE)
    pins_s.encoded |=> (O_DOUT == ($past(O_CARRIER_ON) ^ $past(pins_s.sclk)));
  endproperty
  a_encoded: assert property (p_encoded)
    else $error("Encoded symbol is not data XOR clock");

  property p_marker;
    @(posedge I_CLK_SYS) disable iff (!rst_n || !I_CE)
    (rise && state == ST_RUN && pins_s.hs_ok && !pins_s.cm_ov && clip_hi
      && mark_cnt == MARK_LAST) |=> !bit_q;
  endproperty
  a_marker: assert property (p_marker)
    else $error("Missing clip marker bit");

  property p_no_supply;
    @(posedge I_CLK_SYS) disable iff (!rst_n || !I_CE)
    (rise && !pins_s.hs_ok) |=> !bit_q ##2 !O_CARRIER_ON;
  endproperty
  a_no_supply: assert property (p_no_supply)
    else $error("Stream not zero without high-side supply");

  property p_overvolt;
    @(posedge I_CLK_SYS) disable iff (!rst_n || !I_CE)
    (rise && state == ST_RUN && pins_s.hs_ok && pins_s.cm_ov) |=> bit_q;
  endproperty
  a_overvolt: assert property (p_overvolt)
    else $error("Stream not one under overvoltage");

endmodule : ibm_modulator

/* File: hw/ibm_pkg.sv */
package ibm_pkg;

  // Data widths
  localparam int X_W   = 16;
  localparam int INT_W = 24;
  localparam int SUM_W = 26;

  // Startup: last period count, so output valid after 32 sample clock periods
  localparam logic [4:0] STARTUP_LAST = 5'h1F;
  // Chopper toggles every 16 periods, a full cycle every 32
  localparam logic [3:0] CHOP_LAST    = 4'hF;
  // Clip marker spacing of 128 periods
  localparam logic [6:0] MARK_LAST    = 7'h7F;

  // Input codes at or beyond CLIP_POS and CLIP_NEG are clipped; then the integrator limits and the DAC level
  localparam logic signed [X_W-1:0]   CLIP_POS  = 16'sh7FFF;
  localparam logic signed [X_W-1:0]   CLIP_NEG  = -16'sh7FFF;
  localparam logic signed [INT_W-1:0] INT_MAX   = 24'sh7FFFFF;
  localparam logic signed [INT_W-1:0] INT_MIN   = -24'sh7FFFFF;
  localparam logic signed [INT_W-1:0] DAC_LEVEL = 24'sh007FFF;

  // Barrier carrier of the on-off keying link, MHz (behavioural only)
  localparam int CARRIER_MHZ    = 480;
  // Highest sample clock the far side may supply, MHz
  localparam int SAMPLE_MAX_MHZ = 21;

  typedef struct packed {
    logic sclk;
    logic hs_ok;
    logic cs_ok;
    logic cm_ov;
    logic encoded;
  } ibm_pins_s;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_START = 3'b010,
    ST_RUN   = 3'b100
  } ibm_state_e;

endpackage : ibm_pkg

/* File: verif/ibm_filter_model.sv */
module ibm_filter_model
  import ibm_pkg::*;
(
  // Control
  input  wire logic        i_clk,
  input  wire logic        i_run,
  // Stream
  input  wire logic        i_dout,
  // Sample clock and tallies
  output logic             o_sclk,
  output logic [15:0]      o_rises,
  output logic [15:0]      o_ones
);
  timeunit 1ns;
  timeprecision 1ps;
  // Half period in system cycles, 6.25 MHz
  localparam int HALF = 8;
  int cnt = 0;
  initial
  begin
    o_sclk  = 1'b0;
    o_rises = 16'h0000;
    o_ones  = 16'h0000;
  end
  always @(negedge i_clk)
  begin
    if (i_run || o_sclk)
    begin
      if (cnt == HALF - 1)
      begin
        cnt = 0;
        o_sclk <= ~o_sclk;
        if (!o_sclk)
        begin
          o_rises <= o_rises + 16'h0001;
          o_ones  <= o_ones + {15'h0000, i_dout};
        end
      end
      else
        cnt = cnt + 1;
    end
  end
endmodule : ibm_filter_model

/* File: verif/ibm_modulator_tb.sv */
module ibm_modulator_tb
  import ibm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk, nrst, ce, hs, cs, cmov, enc, run, sclk;
  logic signed [X_W-1:0] ain;
  logic                  dout, car, chop, valid, prev;
  logic [15:0]           rises, ones, k;
  int                    n_fail = 0;
  int                    checks_done = 0;
  int                    cyc = 0;
  int                    low_chg = 0;
  int                    edges = 0;

  ibm_modulator dut (.I_CLK_SYS(clk), .I_NRST(nrst), .I_CE(ce),
    .I_SAMPLE_CLOCK_IN(sclk), .I_HIGH_SIDE_SUPPLY(hs), .I_CONTROLLER_SIDE_SUPPLY(cs),
    .I_CM_OVERVOLTAGE(cmov), .I_ENCODED(enc), .I_AIN_SAMPLE(ain), .O_DOUT(dout),
    .O_CARRIER_ON(car), .O_CHOPPER(chop), .O_VALID(valid));
  ibm_filter_model far (.i_clk(clk), .i_run(run), .i_dout(dout), .o_sclk(sclk),
    .o_rises(rises), .o_ones(ones));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Stream edge monitor and run limit
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (dout !== prev && !enc && !sclk)
      low_chg = low_chg + 1;
    if (dout !== prev)
      edges = edges + 1;
    prev = dout;
    if (cyc == 60000)
    begin
      n_fail = n_fail + 1;
      summarize();
    end
  end

  task automatic chk(string nm, logic [15:0] lo, logic [15:0] hi, logic [15:0] got);
    checks_done = checks_done + 1;
    if ((got < lo) !== 1'b0 || (got > hi) !== 1'b0)
    begin
      n_fail = n_fail + 1;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : chk

  task automatic window(int n, output logic [15:0] got);
    logic [15:0] o0;
    repeat (10) @(posedge sclk);
    @(negedge clk);
    o0 = ones;
    repeat (n) @(posedge sclk);
    @(negedge clk);
    got = ones - o0;
  endtask : window

  task automatic wait_chop();
    logic c;
    c = chop;
    for (int i = 0; i < 2000 && chop === c; i++)
      @(negedge clk);
  endtask : wait_chop

  task automatic t_start();
    logic [15:0] r0;
    int          bad;
    bad = 0;
    cs = 1'b1;
    repeat (10) @(negedge clk);
    r0 = rises;
    run = 1'b1;
    for (int i = 0; i < 1000 && valid !== 1'b1; i++)
    begin
      if (dout !== 1'b0)
        bad = bad + 1;
      @(negedge clk);
    end
    chk("rises_to_valid", 16'd32, 16'd32, rises - r0);
    chk("dout_before_valid", 16'd0, 16'd0, bad[15:0]);
  endtask : t_start

  task automatic t_chop();
    logic [15:0] r1;
    wait_chop();
    r1 = rises;
    wait_chop();
    chk("chop_rises", 16'd16, 16'd16, rises - r1);
  endtask : t_chop

  task automatic t_level(logic signed [X_W-1:0] x, logic [15:0] lo, logic [15:0] hi);
    ain = x;
    window(256, k);
    chk("ones_in_256", lo, hi, k);
  endtask : t_level

  task automatic t_fail();
    hs = 1'b0;
    window(128, k);
    chk("hs_low_ones", 16'd0, 16'd0, k);
    chk("carrier_off", 16'd0, 16'd0, {15'h0000, car});
    hs = 1'b1;
    cmov = 1'b1;
    window(128, k);
    chk("cm_ov_ones", 16'd128, 16'd128, k);
    chk("carrier_on", 16'd1, 16'd1, {15'h0000, car});
  endtask : t_fail

  task automatic t_enc();
    int e0;
    enc = 1'b1;
    repeat (5) @(posedge sclk);
    e0 = edges;
    window(16, k);
    chk("enc_one_samples", 16'd16, 16'd16, k);
    chk("enc_edges", 16'd50, 16'd54, 16'(edges - e0));
    cmov = 1'b0;
    hs = 1'b0;
    window(16, k);
    chk("enc_zero_samples", 16'd0, 16'd0, k);
  endtask : t_enc

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    hs = 1'b1;
    cs = 1'b0;
    cmov = 1'b0;
    enc = 1'b0;
    run = 1'b0;
    prev = 1'b0;
    ain = '0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (5) @(negedge clk);
    t_start();
    t_chop();
    t_level(16'sh0000, 16'd122, 16'd134);
    t_level(16'sh4000, 16'd186, 16'd198);
    t_level(-16'sh4000, 16'd58, 16'd70);
    t_level(CLIP_POS, 16'd254, 16'd254);
    t_level(CLIP_NEG, 16'd2, 16'd2);
    t_fail();
    chk("uncoded_change_clk_low", 16'd0, 16'd0, low_chg[15:0]);
    t_enc();
    summarize();
  end
endmodule : ibm_modulator_tb
